/* File: design/sarp_consts.svh */
// timing and width constants for the serial converter readout port
`ifndef SARP_CONSTS_SVH
`define SARP_CONSTS_SVH
`define SARP_RES_BITS      12
`define SARP_CLK_PERIOD_NS 8
`define SARP_CONVERT_STROBE_TIME_NS  1500
`define SARP_CONVERT_STROBE_CYCLES   ((`SARP_CONVERT_STROBE_TIME_NS + `SARP_CLK_PERIOD_NS - 1) / `SARP_CLK_PERIOD_NS)
`define SARP_CNT_W         8
`define SARP_BIT_W         4
`endif

/* File: design/sarp_pkg.sv */
// types for the serial converter readout port
package sarp_pkg;
  typedef enum logic [1:0] {
    SARP_SLEEP,
    SARP_CONVERT,
    SARP_READOUT
  } sarp_state_t;
endpackage

/* File: design/sarp_top.sv */
// digital side of a 12-bit sampling converter with a three-wire serial result port
//
// Behaviour
// - rising strobe edge starts a conversion
// - power down automatically after conversion ends if strobe is still high
// - output driven only while strobe is low
// - while enabled, output changes only on shift clock falls
// - result sent most significant bit first
// - twelve result bits, then zeros forever
// - strobe rise releases output to high impedance
// - strobe fall presents top result bit at once
// - strobe fall wakes device and acquires input, at conversion end if one is running
`timescale 1ns/1ns
`include "sarp_consts.svh"

module sarp_top
  import sarp_pkg::*;
(
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      NRST_I,
  input  wire logic                      CONVERT_STROBE_I,
  input  wire logic                      SHIFT_CLK_I,
  input  wire logic [`SARP_RES_BITS-1:0] SAMPLE_I,
  output logic                           SERIAL_RESULT_OUT_O,
  output logic                           SERIAL_RESULT_OE_O,
  output logic                           POWERED_O,
  output logic                           ACQUIRE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic       strb_s1_r;
  logic       strb_s2_r;
  logic       strb_d_r;
  logic       sck_s1_r;
  logic       sck_s2_r;
  logic       sck_d_r;
  logic       strb_rise;
  logic       strb_fall;
  logic       sck_fall;

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      strb_s1_r <= 1'b0;
      strb_s2_r <= 1'b0;
      strb_d_r  <= 1'b0;
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_d_r   <= 1'b0;
    end else begin
      strb_s1_r <= CONVERT_STROBE_I;
      strb_s2_r <= strb_s1_r;
      strb_d_r  <= strb_s2_r;
      sck_s1_r  <= SHIFT_CLK_I;
      sck_s2_r  <= sck_s1_r;
      sck_d_r   <= sck_s2_r;
    end
  end

  assign strb_rise = strb_s2_r & ~strb_d_r;
  assign strb_fall = ~strb_s2_r & strb_d_r;
  assign sck_fall  = ~sck_s2_r & sck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing and power state
  sarp_state_t                   state_r;
  logic [`SARP_CNT_W-1:0]        convert_strobe_cnt_r;
  logic [`SARP_RES_BITS-1:0]     result_r;
  localparam logic [`SARP_CNT_W-1:0] CONVERT_STROBE_LAST = `SARP_CNT_W'(`SARP_CONVERT_STROBE_CYCLES - 1);

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      state_r    <= SARP_SLEEP;
      convert_strobe_cnt_r <= '0;
      result_r   <= '0;
    end else begin
      case (state_r)
        SARP_SLEEP: begin
          if (strb_rise) begin
            state_r    <= SARP_CONVERT;
            convert_strobe_cnt_r <= '0;
          end else if (strb_fall) begin
            state_r <= SARP_READOUT;
          end
        end
        SARP_CONVERT: begin
          if (convert_strobe_cnt_r == CONVERT_STROBE_LAST) begin
            result_r <= SAMPLE_I;
            // strobe already low: wake into acquisition
            if (strb_s2_r) begin
              state_r <= SARP_SLEEP;
            end else begin
              state_r <= SARP_READOUT;
            end
          end else begin
            convert_strobe_cnt_r <= convert_strobe_cnt_r + `SARP_CNT_W'(1);
          end
        end
        SARP_READOUT: begin
          // wake and acquire until next rise
          if (strb_rise) begin
            state_r    <= SARP_CONVERT;
            convert_strobe_cnt_r <= '0;
          end
        end
        default: state_r <= SARP_SLEEP;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      POWERED_O <= 1'b0;
      ACQUIRE_O <= 1'b0;
    end else begin
      POWERED_O <= (state_r != SARP_SLEEP);
      ACQUIRE_O <= (state_r == SARP_READOUT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial shifter
  logic [`SARP_RES_BITS-1:0] shift_r;

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      shift_r             <= '0;
      SERIAL_RESULT_OUT_O <= 1'b0;
      SERIAL_RESULT_OE_O  <= 1'b0;
    end else if (strb_rise) begin
      SERIAL_RESULT_OE_O  <= 1'b0;
      SERIAL_RESULT_OUT_O <= 1'b0;
    end else if (strb_fall) begin
      SERIAL_RESULT_OE_O  <= 1'b1;
      SERIAL_RESULT_OUT_O <= result_r[`SARP_RES_BITS-1];
      shift_r             <= {result_r[`SARP_RES_BITS-2:0], 1'b0};
    end else if (sck_fall && SERIAL_RESULT_OE_O) begin
      // msb first, zeros fill in behind
      SERIAL_RESULT_OUT_O <= shift_r[`SARP_RES_BITS-1];
      shift_r             <= {shift_r[`SARP_RES_BITS-2:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [`SARP_BIT_W-1:0] nbits_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) nbits_r <= '0;
    else if (strb_fall) nbits_r <= '0;
    else if (sck_fall && SERIAL_RESULT_OE_O && nbits_r != 4'hf) nbits_r <= nbits_r + 4'h1;
  end
  // copy of the word at strobe fall, kept apart from the shifter
  logic [`SARP_RES_BITS-1:0] frame_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      frame_r <= '0;
    end else if (strb_fall) begin
      frame_r <= result_r;
    end
  end

  a_oe_when_low: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    SERIAL_RESULT_OE_O |-> !strb_d_r)
    else $error("output enabled while strobe high");
  a_rise_releases: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    strb_rise |=> !SERIAL_RESULT_OE_O)
    else $error("output not released after strobe rise");
  a_fall_top_bit: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    strb_fall |=> SERIAL_RESULT_OE_O && SERIAL_RESULT_OUT_O == $past(result_r[`SARP_RES_BITS-1]))
    else $error("top bit not presented on strobe fall");
  a_change_on_fall: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    SERIAL_RESULT_OE_O && $past(SERIAL_RESULT_OE_O) && $changed(SERIAL_RESULT_OUT_O)
      |-> $past(sck_fall))
    else $error("output changed without shift clock fall");
  a_trailing_zero: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    SERIAL_RESULT_OE_O && nbits_r >= 4'hc |-> !SERIAL_RESULT_OUT_O)
    else $error("nonzero after twelve bits");
  a_msb_order: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    sck_fall && SERIAL_RESULT_OE_O && !strb_fall && !strb_rise |=> SERIAL_RESULT_OUT_O == $past(shift_r[11]))
    else $error("bit order wrong");
  a_convert_strobe_starts: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    strb_rise |=> state_r == SARP_CONVERT)
    else $error("conversion not started");
  a_auto_sleep: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == SARP_CONVERT && convert_strobe_cnt_r == CONVERT_STROBE_LAST && strb_s2_r |=> state_r == SARP_SLEEP)
    else $error("no power down after conversion");
  a_convert_strobe_wake: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == SARP_CONVERT && convert_strobe_cnt_r == CONVERT_STROBE_LAST && !strb_s2_r |=> state_r == SARP_READOUT)
    else $error("no acquisition after conversion with strobe low");
  a_sleep_unpowered: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == SARP_SLEEP |=> !POWERED_O)
    else $error("powered while asleep");
  a_acquire_state: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == SARP_READOUT |=> ACQUIRE_O)
    else $error("acquire flag missing while awake");
  a_oe_held_low: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    SERIAL_RESULT_OE_O && !strb_rise |=> SERIAL_RESULT_OE_O)
    else $error("output released without strobe rise");
  a_powered_on_start: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    strb_rise |-> ##2 POWERED_O)
    else $error("not powered after strobe rise");
  a_frame_bits: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    SERIAL_RESULT_OE_O && nbits_r <= 4'hb |-> SERIAL_RESULT_OUT_O == frame_r[4'hb - nbits_r])
    else $error("serial bit differs from captured result");

  ////////////////////////////////////////////////////////////////////////////
  // coverage of the main scenarios
  c_conversion: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == SARP_CONVERT ##1 state_r == SARP_SLEEP);
  c_readout: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I) strb_fall);
  c_zeros: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I) nbits_r == 4'he);
  c_early_fall: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == SARP_CONVERT && strb_fall);
  c_wake: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    state_r == SARP_CONVERT ##1 state_r == SARP_READOUT);

endmodule

/* File: tb/sarp_host_model.sv */
// host model that drives the convert strobe and shift clock and shifts the result in
`timescale 1ns/1ns
module sarp_host_model (
  input  wire logic clk_i,
  input  wire logic data_i,
  input  wire logic oe_i,
  output logic      strobe_o,
  output logic      sck_o
);
  logic line;
  logic last_r = 1'b0;
  // released line shows the inverse of its last driven value
  assign line = oe_i ? data_i : ~last_r;
  always @(posedge clk_i) if (oe_i) last_r <= data_i;
  initial begin
    strobe_o = 1'b0;
    sck_o = 1'b0;
  end
  task automatic start_convert_strobe(input int hold);
    @(posedge clk_i) strobe_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
  endtask
  task automatic read_out(output logic [15:0] word);
    @(posedge clk_i) strobe_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    sck_o <= 1'b1;
    word = {15'h0, line};
    for (int i = 0; i < 15; i++) begin
      repeat (5) @(posedge clk_i);
      sck_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      sck_o <= 1'b1;
      word = {word[14:0], line};
    end
  endtask
endmodule

/* File: tb/sarp_top_tb.sv */
// self-checking bench for the serial converter readout port
`timescale 1ns/1ns
module sarp_top_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] sample = 12'h000;
  logic        strobe;
  logic        sck;
  logic        serial_result_out;
  logic        oe;
  logic        powered;
  logic        acquire;
  int          n_mismatch = 0;
  int          n_checks = 0;
  always #4 clk = ~clk;
  sarp_top i_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .CONVERT_STROBE_I(strobe), .SHIFT_CLK_I(sck),
    .SAMPLE_I(sample), .SERIAL_RESULT_OUT_O(serial_result_out), .SERIAL_RESULT_OE_O(oe), .POWERED_O(powered),
    .ACQUIRE_O(acquire));
  sarp_host_model i_host (.clk_i(clk), .data_i(serial_result_out), .oe_i(oe), .strobe_o(strobe), .sck_o(sck));
  task automatic compare(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic convert(input logic [11:0] v);
    @(posedge clk) sample <= v;
    i_host.start_convert_strobe(5);
    @(negedge clk);
    compare("oe", 16'h0, {15'h0, oe});
    compare("powered", 16'h1, {15'h0, powered});
    // conversion runs 188 cycles from the edge that sees the rise
    repeat (184) @(posedge clk);
    @(negedge clk);
    compare("powered", 16'h1, {15'h0, powered});
    repeat (11) @(posedge clk);
    // input moves after the latch point
    sample <= ~v;
    @(negedge clk);
    compare("powered", 16'h0, {15'h0, powered});
    compare("acquire", 16'h0, {15'h0, acquire});
  endtask
  task automatic readout(input logic [11:0] v);
    logic [15:0] word;
    i_host.read_out(word);
    @(negedge clk);
    compare("word", {v, 4'h0}, word);
    compare("oe", 16'h1, {15'h0, oe});
    compare("acquire", 16'h1, {15'h0, acquire});
    compare("powered", 16'h1, {15'h0, powered});
  endtask
  task automatic early_fall(input logic [11:0] prev);
    i_host.start_convert_strobe(50);
    readout(prev);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic after_reset();
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    compare("oe", 16'h0, {15'h0, oe});
    compare("powered", 16'h0, {15'h0, powered});
    compare("acquire", 16'h0, {15'h0, acquire});
  endtask
  initial begin
    after_reset();
    convert(12'h801);
    readout(12'h801);
    convert(12'h7fe);
    readout(12'h7fe);
    early_fall(12'h7fe);
    complete_run();
  end
endmodule
